// ===== bench/chan_dma_partner.sv
`default_nettype none
module chan_dma_partner (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       req,
    input  wire logic [3:0] dly,
    output wire logic       ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;
    // The memory side grants a unit only while it is requested, after dly busy cycles.
    // Busy cycles pause during peripheral stalls but keep their count, so long waits still finish.
    assign ack = req && (wait_reg >= dly);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 4'h0;
        end else if (ack) begin
            wait_reg <= 4'h0;
        end else if (req && wait_reg != 4'hf) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule // chan_dma_partner
`default_nettype wire

// ===== bench/chan_dma_regs_chk.sv
`default_nettype none
module chan_dma_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        rx_ready,
    input wire logic        tx_ready,
    input wire logic        rx_xfer_ack,
    input wire logic        tx_xfer_ack,
    input wire logic        rx_xfer_req,
    input wire logic        tx_xfer_req,
    input wire logic [31:0] rx_xfer_addr,
    input wire logic        rx_channel_enable,
    input wire logic        tx_channel_enable,
    input wire logic        rx_buffer_done_flag,
    input wire logic        tx_buffer_done_flag,
    input wire logic        rx_all_buffers_full_flag,
    input wire logic        tx_all_buffers_empty_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;
    a_rx_req_gate: assert property (rx_xfer_req |-> rx_channel_enable && rx_ready)
        else $error("rx request without enable or ready");
    a_tx_req_gate: assert property (tx_xfer_req |-> tx_channel_enable && tx_ready)
        else $error("tx request without enable or ready");
    a_rx_dis_cmd: assert property (wr && paddr == 12'h120 && pwdata[1] |=> !rx_channel_enable)
        else $error("rx disable command ignored");
    a_tx_en_cmd: assert property (wr && paddr == 12'h120 && pwdata[8] && !pwdata[9]
        |=> tx_channel_enable) else $error("tx enable command ignored");
    a_rx_done_cause: assert property ($rose(rx_buffer_done_flag)
        |-> $past(rx_xfer_req && rx_xfer_ack)) else $error("rx done without transfer");
    a_tx_done_cause: assert property ($rose(tx_buffer_done_flag)
        |-> $past(tx_xfer_req && tx_xfer_ack)) else $error("tx done without transfer");
    a_rx_full_done: assert property (rx_all_buffers_full_flag |-> rx_buffer_done_flag)
        else $error("rx full flag without done flag");
    a_tx_flag_clear: assert property (wr && paddr == 12'h10c && pwdata[15:0] != 16'h0000
        && !tx_xfer_ack |=> !tx_buffer_done_flag && !tx_all_buffers_empty_flag)
        else $error("tx flags not cleared by size write");
    a_rx_addr_hold: assert property (!rx_xfer_ack && !wr |=> ##1 $stable(rx_xfer_addr))
        else $error("rx address moved without transfer");
endmodule // chan_dma_chk
bind chan_dma_regs chan_dma_chk u_chk (.*);
`default_nettype wire

// ===== bench/peripheral_dma_buffer_regs_test.sv
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    $display("mismatch %s exp %h got %h", n, e, g); err_count++; end end
module peripheral_dma_buffer_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, rx_ready, tx_ready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rx_xfer_addr, tx_xfer_addr, e_m, q, v[8], exp_q[$];
    logic [3:0]  dly;
    wire         pready, pslverr, rx_xfer_req, tx_xfer_req, rx_xfer_ack, tx_xfer_ack;
    wire         rx_channel_enable, tx_channel_enable, rx_buffer_done_flag;
    wire         tx_buffer_done_flag, rx_all_buffers_full_flag, tx_all_buffers_empty_flag;
    int          err_count = 0, samples_checked = 0, cyc = 0;
    chan_dma_regs #(.HALF_DUPLEX(0)) u_dut (.*);
    chan_dma_partner u_rx_mem (.pclk(pclk), .presetn(presetn), .req(rx_xfer_req),
        .dly(dly), .ack(rx_xfer_ack));
    chan_dma_partner u_tx_mem (.pclk(pclk), .presetn(presetn), .req(tx_xfer_req),
        .dly(dly), .ack(tx_xfer_ack));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Ready toggles at random so transfers also meet peripheral stalls.
    always @(posedge pclk) begin
        rx_ready <= 1'($urandom);
        tx_ready <= 1'($urandom);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            e_m = exp_q.pop_front();
            `CHK("prdata", e_m, prdata)
            `CHK("pslverr", 1'b0, pslverr)
        end
    end
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    initial begin
        void'($urandom(41077));
        {psel, penable, pwrite, rx_ready, tx_ready, presetn} = '0;
        paddr = '0;
        pwdata = '0;
        dly = 4'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(12'h100 + 12'(4 * i), 32'h0);
        rd(12'h128, 32'h0);
        for (int i = 0; i < 8; i++) begin
            v[i] = $urandom;
            apb(1'b1, 12'h100 + 12'(4 * i), v[i]);
        end
        for (int i = 0; i < 8; i++) rd(12'h100 + 12'(4 * i), i[0] ? {16'h0, v[i][15:0]} : v[i]);
        apb(1'b1, 12'h1f0, $urandom);
        rd(12'h1f0, 32'h0);
        // Each unit size, with one reload from the chained buffer on the way.
        for (int u = 0; u < 3; u++) begin
            q = $urandom & 32'hffff_fff0;
            dly = 4'($urandom % 4);
            apb(1'b1, 12'h12c, 32'(u));
            apb(1'b1, 12'h100, $urandom);
            apb(1'b1, 12'h110, q);
            apb(1'b1, 12'h114, 32'h1);
            apb(1'b1, 12'h104, 32'h2);
            apb(1'b1, 12'h120, 32'h1);
            repeat (300) if (!rx_all_buffers_full_flag) @(posedge pclk);
            rd(12'h100, q + (32'h1 << u));
            `CHK("rx_xfer_addr", q + (32'h1 << u), rx_xfer_addr)
            rd(12'h104, 32'h0);
            rd(12'h110, 32'h0);
            rd(12'h114, 32'h0);
            rd(12'h128, 32'h5);
            apb(1'b1, 12'h120, 32'h2);
        end
        dly = 4'h5;
        apb(1'b1, 12'h12c, 32'h1);
        apb(1'b1, 12'h108, q);
        apb(1'b1, 12'h11c, 32'h0);
        apb(1'b1, 12'h10c, 32'h3);
        apb(1'b1, 12'h120, 32'h100);
        repeat (300) if (!tx_all_buffers_empty_flag) @(posedge pclk);
        rd(12'h108, q + 32'h6);
        `CHK("tx_xfer_addr", q + 32'h6, tx_xfer_addr)
        rd(12'h128, 32'hf);
        apb(1'b1, 12'h120, 32'h200);
        apb(1'b1, 12'h10c, 32'h5);
        repeat (20) @(posedge pclk);
        rd(12'h10c, 32'h5);
        rd(12'h128, 32'h5);
        rd(12'h124, 32'h0);
        results();
    end
endmodule // peripheral_dma_buffer_regs_test
`default_nettype wire

// ===== src/chan_dma_defines.vh
`ifndef CHAN_DMA_DEFINES_VH
`define CHAN_DMA_DEFINES_VH

`define OFF_RX_BUFFER_POINTER 12'h100
`define OFF_RX_BUFFER_COUNT   12'h104
`define OFF_TX_BUFFER_POINTER 12'h108
`define OFF_TX_BUFFER_COUNT   12'h10c
`define OFF_RX_CHAIN_POINTER  12'h110
`define OFF_RX_CHAIN_COUNT    12'h114
`define OFF_TX_CHAIN_POINTER  12'h118
`define OFF_TX_CHAIN_COUNT    12'h11c
`define OFF_CHANNEL_CONTROL   12'h120
`define OFF_CHANNEL_STATUS    12'h124
`define OFF_DONE_FLAGS        12'h128
`define OFF_UNIT_SIZE         12'h12c

`define CTL_RX_EN_BIT   0
`define CTL_RX_DIS_BIT  1
`define CTL_TX_EN_BIT   8
`define CTL_TX_DIS_BIT  9

`define FLG_RX_DONE_BIT 0
`define FLG_TX_DONE_BIT 1
`define FLG_RX_FULL_BIT 2
`define FLG_TX_EMPTY_BIT 3

`define PTR_RESET   32'h0000_0000
`define CNT_RESET   16'h0000
`define UNIT_BYTE   2'h0
`define UNIT_HALF   2'h1
`define UNIT_WORD   2'h2

`endif

// ===== src/chan_dma_regs.v
// Notes on behaviour
// RQ1 - Software loads receive start address first.
// RQ2 - Software loads receive size, low sixteen bits.
// RQ3 - Zero receive count stops receive transfers.
// RQ4 - Nonzero receive count and enable moves data.
// RQ5 - Software loads transmit start address.
// RQ6 - Software loads transmit size, low sixteen bits.
// RQ7 - Zero transmit count stops transmit fetches.
// RQ8 - Nonzero transmit count and enable moves data.
// RQ9 - Half duplex shares one current pointer.
// RQ10 - Half duplex shares one current counter.
// RQ11 - Next receive pointer held for chaining.
// RQ12 - Sixteen-bit next receive counter.
// RQ13 - Half duplex shares one next pointer.
// RQ14 - Next transmit pointer held for chaining.
// RQ15 - Half duplex shares one next counter.
// RQ16 - Empty current reloads from next, next cleared.
// RQ17 - Pointer advances one, two or four bytes.
// RQ18 - Requests only while channel enable set.
// RQ19 - Done flags; full/empty when both counts zero.
// RQ20 - Sixteen-bit next transmit counter.
// RQ21 - Reads return live pointer and counter values.
// RQ22 - Counter upper bits read zero, ignore writes.
`include "chan_dma_defines.vh"
`default_nettype none

module chan_dma_regs #(
    parameter HALF_DUPLEX = 0
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        rx_ready,
    input  wire        tx_ready,
    input  wire        rx_xfer_ack,
    input  wire        tx_xfer_ack,
    output wire        rx_xfer_req,
    output wire        tx_xfer_req,
    output reg  [31:0] rx_xfer_addr,
    output reg  [31:0] tx_xfer_addr,
    output wire        rx_channel_enable,
    output wire        tx_channel_enable,
    output wire        rx_buffer_done_flag,
    output wire        tx_buffer_done_flag,
    output wire        rx_all_buffers_full_flag,
    output wire        tx_all_buffers_empty_flag
);

    // Storage is kept per direction; in half duplex the transmit view aliases the receive one.
    reg  [31:0] rx_current_address;
    reg  [15:0] rx_current_size;
    reg  [31:0] rx_following_address;
    reg  [15:0] rx_following_size;
    reg  [31:0] tx_cur_addr_reg;
    reg  [15:0] tx_cur_size_reg;
    reg  [31:0] tx_fol_addr_reg;
    reg  [15:0] tx_fol_size_reg;
    reg         rx_en_reg;
    reg         tx_en_reg;
    reg  [3:0]  flags_reg;
    reg  [1:0]  unit_reg;
    reg  [3:0]  flags_next;
    reg  [31:0] step;
    reg  [31:0] rx_cur_addr_next;
    reg  [15:0] rx_cur_size_next;
    reg  [31:0] rx_fol_addr_next;
    reg  [15:0] rx_fol_size_next;
    reg  [31:0] tx_cur_addr_next;
    reg  [15:0] tx_cur_size_next;
    reg  [31:0] tx_fol_addr_next;
    reg  [15:0] tx_fol_size_next;

    wire [31:0] tx_current_address;
    wire [15:0] tx_current_size;
    wire [31:0] tx_following_address;
    wire [15:0] tx_following_size;
    wire        wr;
    wire        rx_move;
    wire        tx_move;
    wire        rx_last;
    wire        tx_last;
    wire        ctl_wr;
    wire        rx_sz_wr;
    wire        tx_sz_wr;
    wire        hit_rx_ptr;
    wire        hit_rx_cnt;
    wire        hit_tx_ptr;
    wire        hit_tx_cnt;
    wire        hit_rx_nptr;
    wire        hit_rx_ncnt;
    wire        hit_tx_nptr;
    wire        hit_tx_ncnt;
    wire        wr_rx_ptr;
    wire        wr_rx_cnt;
    wire        wr_rx_nptr;
    wire        wr_rx_ncnt;
    wire        wr_tx_ptr;
    wire        wr_tx_cnt;
    wire        wr_tx_nptr;
    wire        wr_tx_ncnt;

    // One decoded select per pointer and counter register drives the write path; the read path decodes paddr in its own case.
    assign hit_rx_ptr  = (paddr == `OFF_RX_BUFFER_POINTER);
    assign hit_rx_cnt  = (paddr == `OFF_RX_BUFFER_COUNT);
    assign hit_tx_ptr  = (paddr == `OFF_TX_BUFFER_POINTER);
    assign hit_tx_cnt  = (paddr == `OFF_TX_BUFFER_COUNT);
    assign hit_rx_nptr = (paddr == `OFF_RX_CHAIN_POINTER);
    assign hit_rx_ncnt = (paddr == `OFF_RX_CHAIN_COUNT);
    assign hit_tx_nptr = (paddr == `OFF_TX_CHAIN_POINTER);
    assign hit_tx_ncnt = (paddr == `OFF_TX_CHAIN_COUNT);

    // In half duplex the transmit addresses write the shared receive storage.
    assign wr_rx_ptr  = wr && (hit_rx_ptr || (HALF_DUPLEX && hit_tx_ptr)); // RQ9
    assign wr_rx_cnt  = wr && (hit_rx_cnt || (HALF_DUPLEX && hit_tx_cnt)); // RQ10
    assign wr_rx_nptr = wr && (hit_rx_nptr || (HALF_DUPLEX && hit_tx_nptr)); // RQ13
    assign wr_rx_ncnt = wr && (hit_rx_ncnt || (HALF_DUPLEX && hit_tx_ncnt)); // RQ15
    assign wr_tx_ptr  = wr && hit_tx_ptr;
    assign wr_tx_cnt  = wr && hit_tx_cnt;
    assign wr_tx_nptr = wr && hit_tx_nptr;
    assign wr_tx_ncnt = wr && hit_tx_ncnt;

    assign tx_current_address   = HALF_DUPLEX ? rx_current_address   : tx_cur_addr_reg; // RQ9
    assign tx_current_size      = HALF_DUPLEX ? rx_current_size      : tx_cur_size_reg; // RQ10
    assign tx_following_address = HALF_DUPLEX ? rx_following_address : tx_fol_addr_reg; // RQ13
    assign tx_following_size    = HALF_DUPLEX ? rx_following_size    : tx_fol_size_reg; // RQ15

    assign pready    = 1'b1;
    assign pslverr   = 1'b0;
    assign wr        = psel & penable & pwrite;
    assign ctl_wr    = wr && (paddr == `OFF_CHANNEL_CONTROL);

    assign rx_channel_enable = rx_en_reg;
    assign tx_channel_enable = tx_en_reg;

    // Requests need both permission and a nonzero count.
    assign rx_xfer_req = rx_en_reg && (rx_current_size != 16'h0000) && rx_ready; // RQ3 RQ4 RQ18
    assign tx_xfer_req = tx_en_reg && (tx_current_size != 16'h0000) && tx_ready; // RQ7 RQ8 RQ18
    assign rx_move = rx_xfer_req && rx_xfer_ack;
    assign tx_move = tx_xfer_req && tx_xfer_ack;
    assign rx_last = rx_move && (rx_current_size == 16'h0001);
    assign tx_last = tx_move && (tx_current_size == 16'h0001);

    assign rx_buffer_done_flag       = flags_reg[`FLG_RX_DONE_BIT];
    assign tx_buffer_done_flag       = flags_reg[`FLG_TX_DONE_BIT];
    assign rx_all_buffers_full_flag  = flags_reg[`FLG_RX_FULL_BIT];
    assign tx_all_buffers_empty_flag = flags_reg[`FLG_TX_EMPTY_BIT];

    // A nonzero size write clears the flags of that direction.
    assign rx_sz_wr = wr && pwdata[15:0] != 16'h0000 && (hit_rx_cnt || hit_rx_ncnt);
    assign tx_sz_wr = wr && pwdata[15:0] != 16'h0000 && (hit_tx_cnt || hit_tx_ncnt);

    always @* begin
        case (unit_reg)
            `UNIT_HALF: step = 32'h0000_0002; // RQ17
            `UNIT_WORD: step = 32'h0000_0004; // RQ17
            default:    step = 32'h0000_0001; // RQ17
        endcase
    end

    always @* begin
        flags_next = flags_reg;
        if (rx_sz_wr || (HALF_DUPLEX && tx_sz_wr)) begin
            flags_next[`FLG_RX_DONE_BIT] = 1'b0;
            flags_next[`FLG_RX_FULL_BIT] = 1'b0;
        end
        if (tx_sz_wr || (HALF_DUPLEX && rx_sz_wr)) begin
            flags_next[`FLG_TX_DONE_BIT] = 1'b0;
            flags_next[`FLG_TX_EMPTY_BIT] = 1'b0;
        end
        // Setting after clearing lets a finishing transfer win over a same-cycle clear.
        if (rx_last) begin
            flags_next[`FLG_RX_DONE_BIT] = 1'b1; // RQ19
            if (rx_following_size == 16'h0000)
                flags_next[`FLG_RX_FULL_BIT] = 1'b1; // RQ19
        end
        if (tx_last) begin
            flags_next[`FLG_TX_DONE_BIT] = 1'b1; // RQ19
            if (tx_following_size == 16'h0000)
                flags_next[`FLG_TX_EMPTY_BIT] = 1'b1; // RQ19
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en_reg <= 1'b0;
            tx_en_reg <= 1'b0;
            flags_reg <= 4'h0;
            unit_reg  <= `UNIT_BYTE;
        end else begin
            flags_reg <= flags_next;
            if (wr && paddr == `OFF_UNIT_SIZE)
                unit_reg <= pwdata[1:0];
            if (ctl_wr) begin // RQ18
                if (pwdata[`CTL_RX_DIS_BIT] || (HALF_DUPLEX && pwdata[`CTL_TX_DIS_BIT]))
                    rx_en_reg <= 1'b0;
                else if (pwdata[`CTL_RX_EN_BIT])
                    rx_en_reg <= 1'b1;
                // In half duplex a receive enable overrides and turns transmit off.
                if (pwdata[`CTL_TX_DIS_BIT] || (HALF_DUPLEX && pwdata[`CTL_RX_DIS_BIT]))
                    tx_en_reg <= 1'b0;
                else if (HALF_DUPLEX && pwdata[`CTL_RX_EN_BIT])
                    tx_en_reg <= 1'b0;
                else if (pwdata[`CTL_TX_EN_BIT]) begin
                    tx_en_reg <= 1'b1;
                    if (HALF_DUPLEX)
                        rx_en_reg <= 1'b0;
                end
            end
        end
    end

    // Receive (and shared) pointer and counter set.
    always @* begin
        rx_cur_addr_next = rx_current_address;
        rx_cur_size_next = rx_current_size;
        rx_fol_addr_next = rx_following_address;
        rx_fol_size_next = rx_following_size;
        if (rx_move || (HALF_DUPLEX && tx_move)) begin
            rx_cur_addr_next = rx_current_address + step; // RQ17
            if (rx_current_size == 16'h0001 && rx_following_size != 16'h0000) begin
                rx_cur_addr_next = rx_following_address; // RQ16
                rx_cur_size_next = rx_following_size; // RQ16
                rx_fol_addr_next = `PTR_RESET; // RQ16
                rx_fol_size_next = `CNT_RESET; // RQ16
            end else begin
                rx_cur_size_next = rx_current_size - 16'h0001;
            end
        end
        // Software writes take precedence over the hardware update of the same cycle.
        if (wr_rx_ptr) begin
            rx_cur_addr_next = pwdata; // RQ9
        end
        if (wr_rx_cnt) begin
            rx_cur_size_next = pwdata[15:0]; // RQ10 RQ22
        end
        if (wr_rx_nptr) begin
            rx_fol_addr_next = pwdata; // RQ11 RQ13
        end
        if (wr_rx_ncnt) begin
            rx_fol_size_next = pwdata[15:0]; // RQ12 RQ15
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_current_address   <= `PTR_RESET;
            rx_current_size      <= `CNT_RESET;
            rx_following_address <= `PTR_RESET;
            rx_following_size    <= `CNT_RESET;
        end else begin
            rx_current_address   <= rx_cur_addr_next;
            rx_current_size      <= rx_cur_size_next;
            rx_following_address <= rx_fol_addr_next;
            rx_following_size    <= rx_fol_size_next;
        end
    end

    // Transmit set, unused storage in half duplex.
    always @* begin
        tx_cur_addr_next = tx_cur_addr_reg;
        tx_cur_size_next = tx_cur_size_reg;
        tx_fol_addr_next = tx_fol_addr_reg;
        tx_fol_size_next = tx_fol_size_reg;
        if (tx_move) begin
            tx_cur_addr_next = tx_cur_addr_reg + step; // RQ17
            if (tx_cur_size_reg == 16'h0001 && tx_fol_size_reg != 16'h0000) begin
                tx_cur_addr_next = tx_fol_addr_reg; // RQ16
                tx_cur_size_next = tx_fol_size_reg; // RQ16
                tx_fol_addr_next = `PTR_RESET; // RQ16
                tx_fol_size_next = `CNT_RESET; // RQ16
            end else begin
                tx_cur_size_next = tx_cur_size_reg - 16'h0001;
            end
        end
        if (wr_tx_ptr) begin
            tx_cur_addr_next = pwdata;
        end
        if (wr_tx_cnt) begin
            tx_cur_size_next = pwdata[15:0]; // RQ22
        end
        if (wr_tx_nptr) begin
            tx_fol_addr_next = pwdata; // RQ14
        end
        if (wr_tx_ncnt) begin
            tx_fol_size_next = pwdata[15:0]; // RQ20
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cur_addr_reg <= `PTR_RESET;
            tx_cur_size_reg <= `CNT_RESET;
            tx_fol_addr_reg <= `PTR_RESET;
            tx_fol_size_reg <= `CNT_RESET;
        end else if (!HALF_DUPLEX) begin
            tx_cur_addr_reg <= tx_cur_addr_next;
            tx_cur_size_reg <= tx_cur_size_next;
            tx_fol_addr_reg <= tx_fol_addr_next;
            tx_fol_size_reg <= tx_fol_size_next;
        end
    end

    // Transfer addresses are registered copies of the live current pointers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_xfer_addr <= `PTR_RESET;
            tx_xfer_addr <= `PTR_RESET;
        end else begin
            rx_xfer_addr <= rx_current_address;
            tx_xfer_addr <= tx_current_address;
        end
    end

    always @* begin
        case (paddr)
            `OFF_RX_BUFFER_POINTER: prdata = rx_current_address; // RQ21
            `OFF_RX_BUFFER_COUNT:   prdata = {16'h0000, rx_current_size}; // RQ22
            `OFF_TX_BUFFER_POINTER: prdata = tx_current_address;
            `OFF_TX_BUFFER_COUNT:   prdata = {16'h0000, tx_current_size}; // RQ22
            `OFF_RX_CHAIN_POINTER:  prdata = rx_following_address;
            `OFF_RX_CHAIN_COUNT:    prdata = {16'h0000, rx_following_size};
            `OFF_TX_CHAIN_POINTER:  prdata = tx_following_address;
            `OFF_TX_CHAIN_COUNT:    prdata = {16'h0000, tx_following_size};
            `OFF_CHANNEL_STATUS:    prdata = {23'h000000, tx_en_reg, 7'h00, rx_en_reg};
            `OFF_DONE_FLAGS:        prdata = {28'h0000000, flags_reg};
            `OFF_UNIT_SIZE:         prdata = {30'h00000000, unit_reg};
            default:                prdata = 32'h0000_0000;
        endcase
    end

endmodule // chan_dma_regs

`default_nettype wire
